// ### sibw_pkg.sv
// Package: constants for the indexed block write target
package sibw_pkg;
  localparam logic [6:0] ADDR_STRAP_LOW = 7'h6B;
  localparam logic [6:0] ADDR_STRAP_MID = 7'h6C;
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h6D;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] REF_TIMEOUT = 4'hF;
  localparam logic [7:0] CFG_RESET = 8'h00;
  typedef enum logic [1:0] {SIBW_STRAP_LOW, SIBW_STRAP_MID, SIBW_STRAP_HIGH} sibw_strap_t;
endpackage

// ### sibw_target.sv
// SMBus indexed block write target with strap-selected address
`timescale 1ns/100ps
module sibw_target #(
  parameter int CFG_BYTES = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic power_good_powerdown_n,
  input wire logic [1:0] address_select_strap,
  input wire logic differential_reference_clock_input,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe,
  output logic powered_down,
  output logic [CFG_BYTES*8-1:0] cfg_bytes
);
  typedef enum logic [2:0] {SIBW_IDLE, SIBW_ADDR, SIBW_INDEX, SIBW_COUNT, SIBW_DATA,
    SIBW_SKIP} sibw_phase_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] pg_s;
    logic [1:0] ref_s;
    logic [1:0] strap_m;
    logic [1:0] strap_r;
    logic scl_p;
    logic sda_p;
    logic ref_p;
    logic [3:0] ref_idle;
    logic strap_taken;
    logic [6:0] my_addr;
    logic pd;
    sibw_phase_t phase;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] idx;
    logic [7:0] cnt;
    logic ack;
    logic [CFG_BYTES*8-1:0] cfg;
  } sibw_state_t;

  sibw_state_t q, d;
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c, ref_alive;

  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    case (s)
      sibw_pkg::SIBW_STRAP_LOW: strap_addr = sibw_pkg::ADDR_STRAP_LOW;
      sibw_pkg::SIBW_STRAP_MID: strap_addr = sibw_pkg::ADDR_STRAP_MID;
      default: strap_addr = sibw_pkg::ADDR_STRAP_HIGH;
    endcase
  endfunction

  assign scl = q.scl_s[1];
  assign sda = q.sda_s[1];
  assign scl_rise = scl && !q.scl_p;
  assign scl_fall = !scl && q.scl_p;
  assign start_c = scl && q.scl_p && q.sda_p && !sda;
  assign stop_c = scl && q.scl_p && !q.sda_p && sda;
  assign ref_alive = q.ref_idle != sibw_pkg::REF_TIMEOUT;

  always_comb
  begin
    d = q;
    d.scl_s = {q.scl_s[0], smb_clk_in};
    d.sda_s = {q.sda_s[0], smb_data_in};
    d.pg_s = {q.pg_s[0], power_good_powerdown_n};
    d.ref_s = {q.ref_s[0], differential_reference_clock_input};
    // Strap pin crosses in through two flops, in step with power-good
    d.strap_m = address_select_strap;
    d.strap_r = q.strap_m;
    d.scl_p = scl;
    d.sda_p = sda;
    d.ref_p = q.ref_s[1];
    // Reference activity watchdog
    if (q.ref_s[1] != q.ref_p)
      d.ref_idle = '0;
    else if (ref_alive)
      d.ref_idle = q.ref_idle + 4'h1;
    // Strap latched once on first power-good high
    if (q.pg_s[1] && !q.strap_taken)
    begin
      d.strap_taken = 1'b1;
      d.my_addr = strap_addr(q.strap_r);
    end
    d.pd = !q.pg_s[1];
    if (q.pd || !q.strap_taken || !ref_alive)
    begin
      d.phase = SIBW_IDLE;
      d.ack = 1'b0;
    end
    else if (start_c)
    begin
      d.phase = SIBW_ADDR;
      d.bitn = '0;
      d.ack = 1'b0;
    end
    else if (stop_c)
    begin
      d.phase = SIBW_IDLE;
      d.ack = 1'b0;
    end
    else if (q.phase != SIBW_IDLE && q.phase != SIBW_SKIP)
    begin
      if (scl_rise && q.bitn <= sibw_pkg::LAST_BIT)
      begin
        d.shreg = {q.shreg[6:0], sda};
        d.bitn = q.bitn + 4'h1;
      end
      if (scl_fall && q.bitn == sibw_pkg::ACK_SLOT && !q.ack)
      begin
        d.ack = 1'b1;
        case (q.phase)
          SIBW_ADDR:
            if (q.shreg[7:1] != q.my_addr || q.shreg[0])
            begin
              d.ack = 1'b0;
              d.phase = SIBW_SKIP;
            end
          SIBW_INDEX: d.idx = q.shreg;
          SIBW_COUNT: d.cnt = q.shreg;
          SIBW_DATA:
          begin
            if (q.cnt != 8'h00 && q.idx < CFG_BYTES)
              d.cfg[q.idx[$clog2(CFG_BYTES)-1:0]*sibw_pkg::BYTE_BITS
                +: sibw_pkg::BYTE_BITS] = q.shreg;
            d.idx = q.idx + 8'h01;
            d.cnt = (q.cnt != 8'h00) ? q.cnt - 8'h01 : 8'h00;
          end
          default: d.ack = 1'b0;
        endcase
      end
      else if (scl_fall && q.ack)
      begin
        d.ack = 1'b0;
        d.bitn = '0;
        case (q.phase)
          SIBW_ADDR: d.phase = SIBW_INDEX;
          SIBW_INDEX: d.phase = SIBW_COUNT;
          default: d.phase = SIBW_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.ref_idle <= sibw_pkg::REF_TIMEOUT;
      q.pd <= 1'b1;
      q.phase <= SIBW_IDLE;
      q.cfg <= {CFG_BYTES{sibw_pkg::CFG_RESET}};
    end
    else
      q <= d;
  end

  assign smb_data_out = 1'b0;
  assign smb_data_oe = q.ack;
  assign powered_down = q.pd;
  assign cfg_bytes = q.cfg;

  a_ack_needs_match: assert property (@(posedge clk) disable iff (reset)
    $rose(q.ack) && q.phase == SIBW_ADDR |-> q.shreg[7:1] == q.my_addr && !q.shreg[0])
    else $error("ack given to foreign address");
  a_ack_ref_dead: assert property (@(posedge clk) disable iff (reset)
    !ref_alive |=> !q.ack)
    else $error("ack while reference clock stopped");
  a_ack_released: assert property (@(posedge clk) disable iff (reset)
    q.ack && scl_fall |=> !q.ack)
    else $error("ack not released");
  a_strap_fixed: assert property (@(posedge clk) disable iff (reset)
    q.strap_taken |=> $stable(q.my_addr))
    else $error("target address changed");
  a_pd_follows: assert property (@(posedge clk) disable iff (reset)
    !q.pg_s[1] |=> q.pd)
    else $error("power-down not entered");
  a_idle_in_pd: assert property (@(posedge clk) disable iff (reset)
    q.pd |=> q.phase == SIBW_IDLE)
    else $error("active in power-down");
  a_stop_idles: assert property (@(posedge clk) disable iff (reset)
    stop_c |=> q.phase == SIBW_IDLE)
    else $error("stop not honoured");
  a_data_store: assert property (@(posedge clk) disable iff (reset)
    q.phase == SIBW_DATA && scl_fall && q.bitn == sibw_pkg::ACK_SLOT && !q.ack
    && q.cnt != 8'h00 && ref_alive && !q.pd && !start_c && !stop_c
    |=> q.idx == $past(q.idx) + 8'h01)
    else $error("index not advanced");
  a_ack_slot_only: assert property (@(posedge clk) disable iff (reset)
    $rose(q.ack) |-> q.bitn == sibw_pkg::ACK_SLOT)
    else $error("ack outside the ninth bit");
  a_addr_to_index: assert property (@(posedge clk) disable iff (reset)
    q.phase == SIBW_ADDR && q.ack && scl_fall && ref_alive && !q.pd && q.strap_taken
    |=> q.phase == SIBW_INDEX)
    else $error("index phase not entered");
  a_count_to_data: assert property (@(posedge clk) disable iff (reset)
    q.phase == SIBW_COUNT && q.ack && scl_fall && ref_alive && !q.pd && q.strap_taken
    |=> q.phase == SIBW_DATA)
    else $error("data phase not entered");
  a_cfg_held_pd: assert property (@(posedge clk) disable iff (reset)
    q.pd |=> $stable(q.cfg))
    else $error("config written in power-down");
  a_cfg_held_ref: assert property (@(posedge clk) disable iff (reset)
    !ref_alive |=> $stable(q.cfg))
    else $error("config written without reference clock");
  a_skip_silent: assert property (@(posedge clk) disable iff (reset)
    q.phase == SIBW_SKIP |=> !q.ack)
    else $error("ack while ignoring a transfer");
endmodule

// ### sibw_host.sv
// SMBus host model that drives clock and data toward the targets
`timescale 1ns/100ps
module sibw_host (
  input wire logic clk,
  input wire logic dev_oe,
  output logic scl,
  output wire logic sda
);
  logic d_q = 1'b1;
  initial scl = 1'b1;
  // Released data goes to the pull-up level unless a target pulls low
  assign sda = d_q & ~dev_oe;
  task automatic hold;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic start;
    hold();
    d_q = 1'b0;
    hold();
    scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--)
    begin
      hold();
      d_q = (i < 0) | b[i[2:0]];
      hold();
      scl = 1'b1;
      ack = ~sda;
      hold();
      scl = 1'b0;
    end
  endtask
  task automatic stop;
    hold();
    d_q = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    d_q = 1'b1;
    hold();
  endtask
endmodule

// ### sibw_target_bench.sv
// Bench: one host model and three targets, one for each strap code
`timescale 1ns/100ps
module sibw_target_bench;
  logic clk = 0, reset = 1, pg = 0, ref_clk = 0, ref_on = 1;
  logic [5:0] strap = 6'h24;
  logic [2:0] oe, pd, dout;
  logic [191:0] cfg, e = '0;
  wire logic scl, sda;
  int miscompares = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (ref_on) ref_clk <= #1 ~ref_clk;
  sibw_host i_sibw_host (.clk(clk), .dev_oe(|oe), .scl(scl), .sda(sda));
  sibw_target i_sibw_target [2:0] (.clk(clk), .reset(reset), .power_good_powerdown_n(pg),
    .address_select_strap(strap), .differential_reference_clock_input(ref_clk),
    .smb_clk_in(scl), .smb_data_in(sda), .smb_data_out(dout), .smb_data_oe(oe),
    .powered_down(pd), .cfg_bytes(cfg));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [7:0] x,
    input logic ak);
    logic k;
    i_sibw_host.start();
    i_sibw_host.put({a, 1'b0}, k);
    chk(k, ak);
    i_sibw_host.put(n, k);
    chk(k, ak);
    i_sibw_host.put(x, k);
    chk(k, ak);
    for (int i = 0; i < x; i++)
    begin
      i_sibw_host.put(8'hA0 + n + i[7:0], k);
      chk(k, ak);
    end
    i_sibw_host.stop();
  endtask
  task automatic t_map;
    wr(7'h6B, 8'h05, 8'h03, 1'b1);
    wr(7'h6C, 8'h00, 8'h02, 1'b1);
    wr(7'h6D, 8'h02, 8'h01, 1'b1);
    e[63:40] = 24'hA7A6A5;
    e[79:64] = 16'hA1A0;
    e[151:144] = 8'hA2;
    chk(cfg, e);
    chk(dout, 3'h0);
    wr(7'h6E, 8'h00, 8'h01, 1'b0);
    chk(cfg, e);
    $display("map done");
  endtask
  task automatic t_pd;
    pg = 0;
    cyc(10);
    chk(pd, 3'h7);
    pg = 1;
    cyc(10);
    chk(pd, 3'h0);
    wr(7'h6B, 8'h00, 8'h01, 1'b1);
    e[7:0] = 8'hA0;
    chk(cfg, e);
    $display("powerdown done");
  endtask
  task automatic t_ref;
    ref_on = 0;
    cyc(20);
    wr(7'h6B, 8'h01, 8'h01, 1'b0);
    chk(cfg, e);
    ref_on = 1;
    cyc(10);
    wr(7'h6B, 8'h01, 8'h01, 1'b1);
    e[15:8] = 8'hA1;
    chk(cfg, e);
    $display("refclock done");
  endtask
  initial
  begin
    cyc(10);
    reset = 0;
    pg = 1;
    cyc(10);
    strap = 6'h3F;
    chk(pd, 3'h0);
    t_map();
    t_pd();
    t_ref();
    close_out();
  end
  initial
  begin
    #500000;
    miscompares++;
    close_out();
  end
endmodule
